//--- src/pcr_control.v
// Behaviour
// - unidirectional bit ignored whenever auto-negotiation enable is one
// - with negotiation off, unidir 1 lets transmit always, 0 only on valid link
// - unidirectional bit resets to zero
// - rate field bits 6,13 read fixed 1,0 meaning gigabit
// - collision test bit reads zero always
// - duplex bit reads one always
// - writing one to restart while it reads zero, with negotiation enabled, starts new negotiation; bit resets to zero
// - isolate bit one detaches PCS from MAC; resets to zero
// - power-down bit powers down transceiver quad and drives power-down output
// - auto-negotiation enable resets to one; negotiation runs while set
// - loopback bit loops serial data; resets zero; ignored in reduced ten-bit build
// - writing one to reset bit issues one sync reset pulse, self-clears
// - interface-select register picks 1000BASE-X or SGMII mode
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"

module pcr_control
#(
    parameter REDUCED_TENBIT_IFACE = 0
)
(
    input wire clk_i,
    input wire rst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // status from the pcs
    input wire link_valid_i,
    // controls to the pcs
    output reg tx_enable_o,
    output reg an_enable_o,
    output reg an_restart_o,
    output reg isolate_o,
    output reg powerdown_o,
    output reg loopback_o,
    output reg pcs_soft_reset_o,
    output reg sgmii_mode_o
);

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg unidir;
reg an_restart;
reg isolate;
reg powerdown;
reg an_enable;
reg loopback;
reg soft_reset_req;
reg sgmii_sel;
reg link_meta;
reg link_sync;
wire soft_pulse;
wire restart_pulse;
reg next_unidir;
reg next_an_restart;
reg next_isolate;
reg next_powerdown;
reg next_an_enable;
reg next_loopback;
reg next_soft_reset_req;
reg next_sgmii_sel;
reg next_tx_enable;
reg [31:0] next_prdata;
reg next_pslverr;

// rate code split over its two bit positions, high digit on the low bit
localparam [1:0] RATE_CODE = `PCR_RATE_GIGABIT;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// decodes an address into a known register
function addr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
        addr_hit = (a == target);
    end
endfunction

// assembled control word as software reads it
function [15:0] ctrl_word;
    input u;
    input r;
    input iso;
    input pd;
    input an;
    input lb;
    reg [15:0] w;
    begin
        w = 16'h0000;
        w[`PCR_BIT_UNIDIR] = u;
        w[`PCR_BIT_RATE_LO] = RATE_CODE[1];
        w[`PCR_BIT_RATE_HI] = RATE_CODE[0];
        w[`PCR_BIT_COLL_TEST] = `PCR_COLL_TEST_VAL;
        w[`PCR_BIT_DUPLEX] = `PCR_DUPLEX_VAL;
        w[`PCR_BIT_AN_RESTART] = r;
        w[`PCR_BIT_ISOLATE] = iso;
        w[`PCR_BIT_POWERDOWN] = pd;
        w[`PCR_BIT_AN_ENABLE] = an;
        w[`PCR_BIT_LOOPBACK] = lb;
        w[`PCR_BIT_SOFT_RESET] = 1'b0;
        ctrl_word = w;
    end
endfunction

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
// an access is taken once, in the cycle before pready answers
wire access_cyc = psel_i & penable_i & ~pready_o;
wire wr_ctrl = access_cyc & pwrite_i & addr_hit(paddr_i, `PCR_ADDR_CONTROL);
wire wr_mode = access_cyc & pwrite_i & addr_hit(paddr_i, `PCR_ADDR_IF_MODE);

// ----------------------------------------------------------------
// link status synchroniser
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        link_meta <= 1'b0;
        link_sync <= 1'b0;
    end
    else
    begin
        link_meta <= link_valid_i;
        link_sync <= link_meta;
    end
end

// ----------------------------------------------------------------
// writable control bits
// ----------------------------------------------------------------
// next values of the writable bits, loaded by a taken bus write
always @*
begin
    next_unidir = unidir;
    next_an_restart = an_restart;
    next_isolate = isolate;
    next_powerdown = powerdown;
    next_an_enable = an_enable;
    next_loopback = loopback;
    // reset bit clears itself one cycle after the write
    next_soft_reset_req = 1'b0;
    next_sgmii_sel = sgmii_sel;
    if (wr_ctrl)
    begin
        next_unidir = pwdata_i[`PCR_BIT_UNIDIR];
        next_an_restart = pwdata_i[`PCR_BIT_AN_RESTART];
        next_isolate = pwdata_i[`PCR_BIT_ISOLATE];
        next_powerdown = pwdata_i[`PCR_BIT_POWERDOWN];
        next_an_enable = pwdata_i[`PCR_BIT_AN_ENABLE];
        next_loopback = pwdata_i[`PCR_BIT_LOOPBACK];
        next_soft_reset_req = pwdata_i[`PCR_BIT_SOFT_RESET];
    end
    if (wr_mode)
    begin
        next_sgmii_sel = pwdata_i[`PCR_BIT_SGMII];
    end
end

// register stage of the writable bits
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        unidir <= `PCR_RST_UNIDIR;
        an_restart <= `PCR_RST_AN_RESTART;
        isolate <= `PCR_RST_ISOLATE;
        powerdown <= `PCR_RST_POWERDOWN;
        an_enable <= `PCR_RST_AN_ENABLE;
        loopback <= `PCR_RST_LOOPBACK;
        soft_reset_req <= 1'b0;
        sgmii_sel <= `PCR_RST_IF_MODE;
    end
    else
    begin
        unidir <= next_unidir;
        an_restart <= next_an_restart;
        isolate <= next_isolate;
        powerdown <= next_powerdown;
        an_enable <= next_an_enable;
        loopback <= next_loopback;
        soft_reset_req <= next_soft_reset_req;
        sgmii_sel <= next_sgmii_sel;
    end
end

// ----------------------------------------------------------------
// pulse generation
// ----------------------------------------------------------------
// one pulse per written one, not per cycle held
pcr_pulse_gen u_soft_pulse
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(soft_reset_req),
    .pulse_o(soft_pulse)
);

// restart fires on each rising of the restart bit
pcr_pulse_gen u_restart_pulse
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(an_restart),
    .pulse_o(restart_pulse)
);

// ----------------------------------------------------------------
// apb answer
// ----------------------------------------------------------------
// read data and error flag for the access being taken
always @*
begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (access_cyc)
    begin
        if (addr_hit(paddr_i, `PCR_ADDR_CONTROL))
        begin
            if (~pwrite_i)
                next_prdata = {16'h0000, ctrl_word(unidir, an_restart, isolate,
                               powerdown, an_enable, loopback)};
        end
        else if (addr_hit(paddr_i, `PCR_ADDR_IF_MODE))
        begin
            if (~pwrite_i)
                next_prdata = {{31{1'b0}}, sgmii_sel};
        end
        else
        begin
            next_pslverr = 1'b1; // unmapped address
        end
    end
end

// one wait state: the answer stands for the single cycle after the take
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
    end
    else
    begin
        pready_o <= access_cyc;
        pslverr_o <= next_pslverr;
        prdata_o <= next_prdata;
    end
end

// ----------------------------------------------------------------
// outputs to the pcs
// ----------------------------------------------------------------
// transmit permission from negotiation, unidirectional bit and link
always @*
begin
    // negotiation on: unidir ignored, transmit waits for link
    if (an_enable)
        next_tx_enable = link_sync;
    else
        next_tx_enable = unidir | link_sync;
end

// registered copies so every pcs control leaves from a flip-flop
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        tx_enable_o <= 1'b0;
        an_enable_o <= `PCR_RST_AN_ENABLE;
        an_restart_o <= 1'b0;
        isolate_o <= `PCR_RST_ISOLATE;
        powerdown_o <= `PCR_RST_POWERDOWN;
        loopback_o <= `PCR_RST_LOOPBACK;
        pcs_soft_reset_o <= 1'b0;
        sgmii_mode_o <= `PCR_RST_IF_MODE;
    end
    else
    begin
        tx_enable_o <= next_tx_enable;
        an_enable_o <= an_enable;
        an_restart_o <= restart_pulse & an_enable;
        isolate_o <= isolate;
        powerdown_o <= powerdown;
        loopback_o <= (REDUCED_TENBIT_IFACE != 0) ? 1'b0 : loopback;
        pcs_soft_reset_o <= soft_pulse;
        sgmii_mode_o <= sgmii_sel;
    end
end

endmodule

`default_nettype wire

//--- common/pcr_regs.vh
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// register word offsets (byte address = index * 4)
`define PCR_IDX_CONTROL 6'h00
`define PCR_IDX_IF_MODE 6'h14
`define PCR_ADDR_CONTROL 8'h00
`define PCR_ADDR_IF_MODE 8'h50

// control register bit positions
`define PCR_BIT_UNIDIR 5
`define PCR_BIT_RATE_LO 6
`define PCR_BIT_COLL_TEST 7
`define PCR_BIT_DUPLEX 8
`define PCR_BIT_AN_RESTART 9
`define PCR_BIT_ISOLATE 10
`define PCR_BIT_POWERDOWN 11
`define PCR_BIT_AN_ENABLE 12
`define PCR_BIT_RATE_HI 13
`define PCR_BIT_LOOPBACK 14
`define PCR_BIT_SOFT_RESET 15

// fixed read-only values
`define PCR_RATE_GIGABIT 2'h2
`define PCR_COLL_TEST_VAL 1'h0
`define PCR_DUPLEX_VAL 1'h1

// reset values of writable bits
`define PCR_RST_UNIDIR 1'h0
`define PCR_RST_AN_RESTART 1'h0
`define PCR_RST_ISOLATE 1'h0
`define PCR_RST_POWERDOWN 1'h0
`define PCR_RST_AN_ENABLE 1'h1
`define PCR_RST_LOOPBACK 1'h0
`define PCR_RST_IF_MODE 1'h0

// if_mode field
`define PCR_BIT_SGMII 0

`endif

//--- src/pcr_pulse_gen.v
`timescale 1ns/1ps
`default_nettype none

// one-cycle pulse on the rising edge of a request level
module pcr_pulse_gen
(
    input wire clk_i,
    input wire rst_i,
    input wire req_i,
    output reg pulse_o
);

reg req_d;

// edge detect registered onto the output
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        req_d <= 1'b0;
        pulse_o <= 1'b0;
    end
    else
    begin
        req_d <= req_i;
        pulse_o <= req_i & ~req_d;
    end
end

endmodule

`default_nettype wire

//--- dv/pcr_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_control_asserts
(
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire isolate_o,
    input wire powerdown_o,
    input wire an_enable_o,
    input wire an_restart_o,
    input wire pcs_soft_reset_o,
    input wire sgmii_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // taken control write, and control read answer
    wire wr0 = psel_i & penable_i & ~pready_o & pwrite_i & (paddr_i == 8'h00);
    wire rd0 = pready_o & ~pwrite_i & (paddr_i == 8'h00);
    // taken mode register write
    wire wrm = psel_i & penable_i & ~pready_o & pwrite_i & (paddr_i == 8'h50);
    property p_rate; rd0 |-> prdata_o[6] && !prdata_o[13]; endproperty
    a_rate: assert property (p_rate) else $error("rate field wrong");
    property p_coll; rd0 |-> !prdata_o[7]; endproperty
    a_coll: assert property (p_coll) else $error("collision bit set");
    property p_dup; rd0 |-> prdata_o[8]; endproperty
    a_dup: assert property (p_dup) else $error("duplex bit clear");
    property p_rsvd; rd0 |-> prdata_o[4:0] == 5'h00 && prdata_o[31:15] == 17'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    property p_srst; wr0 && pwdata_i[15] |-> ##3 pcs_soft_reset_o ##1 !pcs_soft_reset_o; endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
    property p_iso; wr0 |-> ##2 isolate_o == $past(pwdata_i[10], 2); endproperty
    a_iso: assert property (p_iso) else $error("isolate wrong");
    property p_pd; wr0 |-> ##2 powerdown_o == $past(pwdata_i[11], 2); endproperty
    a_pd: assert property (p_pd) else $error("powerdown wrong");
    property p_an; wr0 |-> ##2 an_enable_o == $past(pwdata_i[12], 2); endproperty
    a_an: assert property (p_an) else $error("an enable wrong");
    property p_rst_pulse; an_restart_o |=> !an_restart_o; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("restart not a pulse");
    property p_mode; wrm |-> ##2 sgmii_mode_o == $past(pwdata_i[0], 2); endproperty
    a_mode: assert property (p_mode) else $error("mode select wrong");
endmodule
bind pcr_control pcr_control_asserts chk_u
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .isolate_o(isolate_o),
    .powerdown_o(powerdown_o),
    .an_enable_o(an_enable_o),
    .an_restart_o(an_restart_o),
    .pcs_soft_reset_o(pcs_soft_reset_o),
    .sgmii_mode_o(sgmii_mode_o)
);
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, link_valid_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, m, d;
    logic pready_o, pslverr_o, er, tx_enable_o, an_enable_o, an_restart_o;
    logic isolate_o, powerdown_o, loopback_o, pcs_soft_reset_o, sgmii_mode_o;
    integer error_cnt = 0, checked = 0, seed = 44, i, r;
    integer n_rs = 0, n_sr = 0, e_rs = 0, e_sr = 0;
    pcr_control dut_u
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .link_valid_i(link_valid_i),
        .tx_enable_o(tx_enable_o),
        .an_enable_o(an_enable_o),
        .an_restart_o(an_restart_o),
        .isolate_o(isolate_o),
        .powerdown_o(powerdown_o),
        .loopback_o(loopback_o),
        .pcs_soft_reset_o(pcs_soft_reset_o),
        .sgmii_mode_o(sgmii_mode_o)
    );
    always #4 clk_i = ~clk_i;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        begin
            @(posedge clk_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= dt;
            @(posedge clk_i);
            penable_i <= 1'b1;
            // wait as long as it takes; only the watchdog ends a hung wait
            do
            begin
                @(posedge clk_i);
            end
            while (pready_o !== 1'b1);
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            checked++;
            if (s !== e)
            begin
                error_cnt++;
                $display("mismatch at %0t: got %h want %h", $time, s, e);
            end
        end
    endtask
    task results;
        begin
            $display("checked %0d error_cnt %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        m = 32'h1140;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(0, 8'h00, 0);
        chk(rd, m);
        chk({an_enable_o, isolate_o, powerdown_o, loopback_o}, 4'h8);
        chk({tx_enable_o, an_restart_o, pcs_soft_reset_o, sgmii_mode_o}, 4'h0);
        $display("test reset done");
        for (i = 0; i < 40; i++)
        begin
            d = $random(seed);
            r = $random(seed);
            link_valid_i <= r[0];
            apb(1, 8'h00, d);
            // model: a reset pulse per written one, a restart on a rising bit with negotiation on
            if (d[15])
                e_sr++;
            if (d[9] && !m[9] && d[12])
                e_rs++;
            m = (d & 32'h5E20) | 32'h0140;
            repeat (6) @(posedge clk_i);
            chk(n_sr, e_sr);
            chk(n_rs, e_rs);
            chk({isolate_o, powerdown_o, an_enable_o, loopback_o}, {m[10], m[11], m[12], m[14]});
            chk(tx_enable_o, m[12] ? link_valid_i : (m[5] | link_valid_i));
            apb(0, 8'h00, 0);
            chk(rd, m);
        end
        $display("test random control done");
        apb(1, 8'h50, 1);
        repeat (3) @(posedge clk_i);
        chk(sgmii_mode_o, 1'b1);
        apb(0, 8'h50, 0);
        chk(rd, 32'h1);
        apb(0, 8'h08, 0);
        chk({er, rd}, {1'b1, 32'h0});
        $display("test map done");
        results;
    end
    // watchdog against a hung handshake
    initial
    begin
        #100000;
        error_cnt++;
        results;
    end
    // counts the one-cycle pulses that the model predicts
    always @(posedge clk_i)
    begin
        if (!rst_i && an_restart_o === 1'b1)
            n_rs <= n_rs + 1;
        if (!rst_i && pcs_soft_reset_o === 1'b1)
            n_sr <= n_sr + 1;
    end
endmodule
`default_nettype wire
